// ==== shared/e1_alarm_cfg.svh ====
// Constants for the E1 receive alarm and error interrupt block.
// Assumes one channel per instance; channel decode happens outside.
//
// Function
// - Declare remote alarm after A bit is 1 in two consecutive non-FRAME_ALIGN_SIGNAL frames.
// - Clear remote alarm after A bit is 0 in two consecutive non-FRAME_ALIGN_SIGNAL frames.
// - Enable register bit 7 reads live remote alarm state; writes ignored.
// - Bit 5 enables interrupt on multiframe remote alarm declare and clear.
// - Bit 3 enables interrupt on each detected line code violation.
// - Bit 2 enables interrupt on frame loss declare and clear.
// - Bit 1 enables interrupt on all-ones alarm declare and clear.
// - Bit 0 enables interrupt on remote alarm declare and clear.
// - All enable bits reset to zero; bit 6 is reserved.
// - Status flags set on their event and clear when status is read.
`ifndef E1_ALARM_CFG_SVH
`define E1_ALARM_CFG_SVH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define ADDR_IRQ_FLAGS 8'h02
`define ADDR_IRQ_ENABLE 8'h03

// -----------------------------------------------------------------------------
// Field positions, shared by the flag and the enable register
// -----------------------------------------------------------------------------
`define BIT_REMOTE_CHG 0
`define BIT_ALL_ONES_CHG 1
`define BIT_FRAME_LOSS_CHG 2
`define BIT_LINE_VIOL 3
`define BIT_KEEP_ZERO 4
`define BIT_MF_REMOTE_CHG 5
`define BIT_RESERVED 6
`define BIT_REMOTE_LIVE 7
`define ENABLE_WR_MASK 8'h3f
`define IRQ_SOURCE_MASK 8'h2f
`define ENABLE_RESET 8'h00
`define FLAGS_RESET 8'h00

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define CLK_MHZ 50
`define REMOTE_ALARM_US 375
`define REMOTE_ALARM_CYC (`REMOTE_ALARM_US * `CLK_MHZ)

`endif

// ==== shared/e1_alarm_pkg.sv ====
// Types for the E1 receive alarm and error interrupt block.
// Assumes the framer supplies its alarm levels in the sys_clk domain.
package e1_alarm_pkg;

  // ---------------------------------------------------------------------------
  // Line side conditions from the receive framer
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic nonfas_strobe;
    logic a_bit;
    logic all_ones_alarm;
    logic frame_loss;
    logic line_violation;
    logic mf_remote_alarm;
  } rx_alarm_in_t;

  // ---------------------------------------------------------------------------
  // Microprocessor register access
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    RA_CLEAR,
    RA_CLEAR_ONE,
    RA_SET,
    RA_SET_ZERO
  } remote_alarm_state_t;

endpackage

// ==== src/remote_alarm_detect.sv ====
// Remote alarm detector working on the A bit of non-FRAME_ALIGN_SIGNAL frames.
// Assumes one strobe per non-FRAME_ALIGN_SIGNAL frame, with a_bit valid in that cycle.
`timescale 1ns/1ps
`include "e1_alarm_cfg.svh"

module remote_alarm_detect (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic nonfas_strobe,
  input wire logic a_bit,
  output logic remote_alarm_live
);
  import e1_alarm_pkg::*;

  remote_alarm_state_t state_q;

  // ---------------------------------------------------------------------------
  // Two-frame persistence filter
  // ---------------------------------------------------------------------------
  // One odd A bit only arms the filter; a second agreeing frame commits it.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= RA_CLEAR;
    end else if (nonfas_strobe) begin
      unique case (state_q)
        RA_CLEAR: state_q <= a_bit ? RA_CLEAR_ONE : RA_CLEAR;
        RA_CLEAR_ONE: state_q <= a_bit ? RA_SET : RA_CLEAR;
        RA_SET: state_q <= a_bit ? RA_SET : RA_SET_ZERO;
        RA_SET_ZERO: state_q <= a_bit ? RA_SET : RA_CLEAR;
      endcase
    end
  end

  assign remote_alarm_live = (state_q == RA_SET) || (state_q == RA_SET_ZERO);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_second_one;
    (state_q == RA_CLEAR_ONE) && nonfas_strobe && a_bit;
  endsequence

  sequence s_second_zero;
    (state_q == RA_SET_ZERO) && nonfas_strobe && !a_bit;
  endsequence

  property p_declare;
    @(posedge sys_clk) disable iff (sys_rst) s_second_one |=> remote_alarm_live;
  endproperty
  a_declare: assert property (p_declare)
    else $error("remote alarm not declared");

  property p_clear;
    @(posedge sys_clk) disable iff (sys_rst) s_second_zero |=> !remote_alarm_live;
  endproperty
  a_clear: assert property (p_clear)
    else $error("remote alarm not cleared");

  property p_no_early_declare;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(remote_alarm_live) |-> $past(nonfas_strobe) && $past(a_bit);
  endproperty
  a_no_early_declare: assert property (p_no_early_declare)
    else $error("remote alarm declared without a frame");

endmodule

// ==== src/e1_rx_alarm_irq_enable.sv ====
// Alarm and error interrupt flags and enables for one E1 receive channel.
// Assumes register requests and framer levels are synchronous to sys_clk.
`timescale 1ns/1ps
`include "e1_alarm_cfg.svh"

module e1_rx_alarm_irq_enable #(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input e1_alarm_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input e1_alarm_pkg::rx_alarm_in_t rx_in,
  output logic remote_alarm_indication,
  output logic irq
);
  import e1_alarm_pkg::*;

  if (ADDR_W != 8) begin : g_bad_addr_w
    $error("ADDR_W must be 8 to match the register request type");
  end

  logic [7:0] alarm_error_irq_enable_q;
  logic [7:0] alarm_error_irq_flags_q;
  logic [7:0] alarm_error_irq_flags_d;
  logic [7:0] events;
  logic [7:0] enable_view;
  logic remote_alarm_live;
  logic live_prev_q;
  logic all_ones_prev_q;
  logic frame_loss_prev_q;
  logic mf_remote_prev_q;
  logic flags_read;
  logic enable_read;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  // ---------------------------------------------------------------------------
  // Remote alarm persistence
  // ---------------------------------------------------------------------------
  remote_alarm_detect u_detect (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .nonfas_strobe(rx_in.nonfas_strobe),
    .a_bit(rx_in.a_bit),
    .remote_alarm_live(remote_alarm_live)
  );

  assign remote_alarm_indication = remote_alarm_live;

  // ---------------------------------------------------------------------------
  // Change detection on alarm levels
  // ---------------------------------------------------------------------------
  // Previous levels reset to the cleared state, so an alarm already present at
  // release still reports one declare event.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      live_prev_q <= 1'b0;
      all_ones_prev_q <= 1'b0;
      frame_loss_prev_q <= 1'b0;
      mf_remote_prev_q <= 1'b0;
    end else begin
      live_prev_q <= remote_alarm_live;
      all_ones_prev_q <= rx_in.all_ones_alarm;
      frame_loss_prev_q <= rx_in.frame_loss;
      mf_remote_prev_q <= rx_in.mf_remote_alarm;
    end
  end

  // Both edges count as events: declare and clear each raise the flag.
  always_comb begin
    events = 8'h00;
    events[`BIT_REMOTE_CHG] = remote_alarm_live ^ live_prev_q;
    events[`BIT_ALL_ONES_CHG] = rx_in.all_ones_alarm ^ all_ones_prev_q;
    events[`BIT_FRAME_LOSS_CHG] = rx_in.frame_loss ^ frame_loss_prev_q;
    events[`BIT_LINE_VIOL] = rx_in.line_violation;
    events[`BIT_MF_REMOTE_CHG] = rx_in.mf_remote_alarm ^ mf_remote_prev_q;
  end

  // ---------------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------------
  assign flags_read = reg_req.rd && hit(reg_req.addr, `ADDR_IRQ_FLAGS);
  assign enable_read = reg_req.rd && hit(reg_req.addr, `ADDR_IRQ_ENABLE);

  // Bit 7 is never stored; it is the detector's state. Bit 6 reads zero.
  always_comb begin
    enable_view = alarm_error_irq_enable_q & `ENABLE_WR_MASK;
    enable_view[`BIT_REMOTE_LIVE] = remote_alarm_live;
  end

  // Enable register; bit 4 is stored as written, software must keep it zero.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      alarm_error_irq_enable_q <= `ENABLE_RESET;
    end else if (reg_req.wr && hit(reg_req.addr, `ADDR_IRQ_ENABLE)) begin
      alarm_error_irq_enable_q <= reg_req.wdata & `ENABLE_WR_MASK;
    end
  end

  // Read clears all flags, but an event in the read cycle is kept for the next
  // read rather than lost between sample and clear.
  always_comb begin
    alarm_error_irq_flags_d = alarm_error_irq_flags_q;
    if (flags_read) begin
      alarm_error_irq_flags_d = 8'h00;
    end
    alarm_error_irq_flags_d = alarm_error_irq_flags_d | (events & `IRQ_SOURCE_MASK);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      alarm_error_irq_flags_q <= `FLAGS_RESET;
    end else begin
      alarm_error_irq_flags_q <= alarm_error_irq_flags_d;
    end
  end

  // Read data is registered; unmapped offsets return zero.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (flags_read) begin
      reg_rdata <= alarm_error_irq_flags_q;
    end else if (enable_read) begin
      reg_rdata <= enable_view;
    end else if (reg_req.rd) begin
      reg_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt request
  // ---------------------------------------------------------------------------
  // Bit 4 is excluded from the sources so a stray write cannot fire the line.
  assign irq = |(alarm_error_irq_flags_q & alarm_error_irq_enable_q & `IRQ_SOURCE_MASK);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_enable_reset;
    @(posedge sys_clk) $past(sys_rst) |-> (alarm_error_irq_enable_q == 8'h00) && !irq;
  endproperty
  a_enable_reset: assert property (p_enable_reset)
    else $error("enables not zero after reset");

  property p_live_readback;
    @(posedge sys_clk) disable iff (sys_rst)
      enable_read |=> (reg_rdata[7] == $past(remote_alarm_live)) && !reg_rdata[6];
  endproperty
  a_live_readback: assert property (p_live_readback)
    else $error("bit 7 not live state");

  property p_mf_change;
    @(posedge sys_clk) disable iff (sys_rst)
      $changed(rx_in.mf_remote_alarm) ##1 alarm_error_irq_enable_q[5] |-> irq;
  endproperty
  a_mf_change: assert property (p_mf_change)
    else $error("multiframe change no irq");

  property p_line_viol;
    @(posedge sys_clk) disable iff (sys_rst)
      rx_in.line_violation |=> alarm_error_irq_flags_q[3];
  endproperty
  a_line_viol: assert property (p_line_viol)
    else $error("line violation not flagged");

  property p_frame_loss;
    @(posedge sys_clk) disable iff (sys_rst)
      $changed(rx_in.frame_loss) |=> alarm_error_irq_flags_q[2];
  endproperty
  a_frame_loss: assert property (p_frame_loss)
    else $error("frame loss change missed");

  property p_all_ones;
    @(posedge sys_clk) disable iff (sys_rst)
      $changed(rx_in.all_ones_alarm) |=> alarm_error_irq_flags_q[1];
  endproperty
  a_all_ones: assert property (p_all_ones)
    else $error("all-ones change missed");

  property p_remote_change;
    @(posedge sys_clk) disable iff (sys_rst)
      $changed(remote_alarm_live) |=> alarm_error_irq_flags_q[0] ##1 1'b1;
  endproperty
  a_remote_change: assert property (p_remote_change)
    else $error("remote change missed");

  property p_read_clears;
    @(posedge sys_clk) disable iff (sys_rst)
      flags_read && (events == 8'h00) |=> (alarm_error_irq_flags_q == 8'h00) && !irq;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("flags not cleared by read");

  property p_irq_holds;
    @(posedge sys_clk) disable iff (sys_rst)
      irq && !flags_read && !(reg_req.wr && hit(reg_req.addr, `ADDR_IRQ_ENABLE)) |=> irq;
  endproperty
  a_irq_holds: assert property (p_irq_holds)
    else $error("irq dropped without clear");

  // A flags read hands over exactly the set that was pending in its cycle.
  property p_read_returns;
    @(posedge sys_clk) disable iff (sys_rst)
      flags_read |=> (reg_rdata == $past(alarm_error_irq_flags_q));
  endproperty
  a_read_returns: assert property (p_read_returns)
    else $error("flags read data wrong");

  // Without a read, no pending flag may vanish; only new events add bits.
  property p_flags_sticky;
    @(posedge sys_clk) disable iff (sys_rst)
      !flags_read |=> ((alarm_error_irq_flags_q & $past(alarm_error_irq_flags_q))
        == $past(alarm_error_irq_flags_q));
  endproperty
  a_flags_sticky: assert property (p_flags_sticky)
    else $error("pending flag lost without read");

  // A write stores the writable bits only; bits 7 and 6 never hold state.
  property p_enable_write;
    @(posedge sys_clk) disable iff (sys_rst)
      reg_req.wr && hit(reg_req.addr, `ADDR_IRQ_ENABLE) |=>
        (alarm_error_irq_enable_q == ($past(reg_req.wdata) & `ENABLE_WR_MASK));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable write not stored");

endmodule

// ==== dv/e1_line_model.sv ====
// Far-end E1 line model: frames the wanted A bit into non-FRAME_ALIGN_SIGNAL strobes and drives alarms.
// Assumes the bench sets a_src and the alarm levels synchronously to sys_clk.
`timescale 1ns/1ps

module e1_line_model #(
  parameter int GAP = 6
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic a_src,
  input wire logic [3:0] lev,
  output e1_alarm_pkg::rx_alarm_in_t rx
);
  import e1_alarm_pkg::*;

  // ---------------------------------------------------------------------------
  // Frame timing
  // ---------------------------------------------------------------------------
  int cnt;
  logic a_last;

  // One non-FRAME_ALIGN_SIGNAL strobe every GAP cycles carries the A bit the detector counts.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt <= 0;
      a_last <= 1'b0;
    end else begin
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      if (cnt == GAP - 1) begin
        a_last <= a_src;
      end
    end
  end

  // Off-strobe the A bit is invalid, so it shows the inverse of the last framed value.
  // That catches a detector that samples the bit outside its strobe.
  assign rx.nonfas_strobe = (cnt == GAP - 1) && !sys_rst;
  assign rx.a_bit = rx.nonfas_strobe ? a_src : !a_last;
  assign rx.all_ones_alarm = lev[0];
  assign rx.frame_loss = lev[1];
  assign rx.line_violation = lev[2];
  assign rx.mf_remote_alarm = lev[3];
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the alarm and error interrupt block.
// Assumes the line model feeds rx_in; expected values come from a bench model.
`timescale 1ns/1ps
`include "e1_alarm_cfg.svh"

module tb_top;
  import e1_alarm_pkg::*;

  // ---------------------------------------------------------------------------
  // Signals and bench model state
  // ---------------------------------------------------------------------------
  logic sys_clk, sys_rst, a_src, ral, irq;
  logic [3:0] lev;
  logic [7:0] rdata, en, flg, v;
  reg_req_t req;
  rx_alarm_in_t rx;
  int bad_count, checked, seed, k, j, b;
  int pos[4] = '{1, 2, 3, 5};

  e1_line_model i_e1_line_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .a_src(a_src),
    .lev(lev), .rx(rx));
  e1_rx_alarm_irq_enable i_e1_rx_alarm_irq_enable (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_req(req), .reg_rdata(rdata), .rx_in(rx), .remote_alarm_indication(ral), .irq(irq));

  // Free-running 50 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic tally_and_finish;
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmp8(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp1(string n, logic e, logic g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask

  // Settle one step past the edge so that edge's updates have landed.
  task automatic clk(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Strobes last one cycle, so the read and write strobes drop at the next edge.
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk) req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk) req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk) req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk) req.wr <= 1'b0;
  endtask

  function automatic logic exp_irq();
    return |(flg & en & `IRQ_SOURCE_MASK);
  endfunction

  // A flags read returns the pending set and empties it, dropping the request line.
  task automatic chk_flags;
    rd(`ADDR_IRQ_FLAGS, v);
    cmp8("flags", flg, v);
    flg = 8'h00;
    cmp1("irq", exp_irq(), irq);
  endtask

  task automatic strobe;
    for (int i = 0; i < 20; i++) begin
      clk(1);
      if (rx.nonfas_strobe === 1'b1) return;
    end
    bad_count++;
    tally_and_finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed = 48;
    bad_count = 0;
    checked = 0;
    sys_rst = 1'b1;
    a_src = 1'b0;
    lev = 4'h0;
    req = '0;
    en = 8'h00;
    flg = 8'h00;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    clk(1);
    rd(`ADDR_IRQ_ENABLE, v);
    cmp8("enable", 8'h00, v);
    chk_flags;
    rd(8'h7e, v);
    cmp8("unmapped", 8'h00, v);
    // Random enables; software leaves bit 4 clear, bits 7 and 6 never store.
    for (k = 0; k < 4; k++) begin
      en = 8'($random(seed)) & 8'hef;
      wr(`ADDR_IRQ_ENABLE, en);
      en = en & `ENABLE_WR_MASK;
      rd(`ADDR_IRQ_ENABLE, v);
      cmp8("enable", en, v);
    end
    en = 8'h01;
    wr(`ADDR_IRQ_ENABLE, en);
    // Remote alarm declare then clear; a single frame must not be enough.
    for (b = 1; b >= 0; b--) begin
      strobe;
      clk(1);
      @(posedge sys_clk) a_src <= b[0];
      strobe;
      clk(1);
      cmp1("remote", !b[0], ral);
      strobe;
      clk(1);
      cmp1("remote", b[0], ral);
      rd(`ADDR_IRQ_ENABLE, v);
      cmp8("enable", {b[0], 7'h01}, v);
      flg[0] = 1'b1;
      cmp1("irq", exp_irq(), irq);
      chk_flags;
    end
    // Each framer level input, flag bits 1, 2, 3 and 5, with its enable set and then cleared.
    for (k = 0; k < 4; k++) begin
      for (j = 0; j < 2; j++) begin
        en = j ? 8'h00 : 8'(1 << pos[k]);
        wr(`ADDR_IRQ_ENABLE, en);
        @(posedge sys_clk) lev[k] <= !lev[k];
        if (k == 2) @(posedge sys_clk) lev[k] <= 1'b0;
        clk(2);
        flg[pos[k]] = 1'b1;
        cmp1("irq", exp_irq(), irq);
        chk_flags;
      end
    end
    // A pending, enabled flag first; a reset in mid-run must drop it and the enables.
    en = 8'h2f;
    wr(`ADDR_IRQ_ENABLE, en);
    @(posedge sys_clk) lev[2] <= 1'b1;
    @(posedge sys_clk) lev[2] <= 1'b0;
    clk(1);
    flg[`BIT_LINE_VIOL] = 1'b1;
    cmp1("irq", exp_irq(), irq);
    @(posedge sys_clk) sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    clk(1);
    en = 8'h00;
    flg = 8'h00;
    cmp1("irq", 1'b0, irq);
    cmp1("remote", 1'b0, ral);
    rd(`ADDR_IRQ_ENABLE, v);
    cmp8("enable", en, v);
    chk_flags;
    tally_and_finish;
  end
endmodule
